// *** verilog/coord_cmd_pkg.sv ***
// Package of shared constants and types for the coordinate command blocks
package coord_cmd_pkg;
    // ========================================
    // Command word layout
    localparam int          WORD_W       = 16;
    localparam int          OPC_W        = 5;
    localparam int          OPC_LSB      = 11;
    localparam int          MODE_W       = 11;
    localparam int          MODE_LSB     = 0;
    localparam logic [4:0]  OPC_MOVE_ABS = 5'h10;
    localparam logic [4:0]  OPC_MOVE_REL = 5'h11;
    localparam logic [4:0]  OPC_OFS_ABS  = 5'h12;
    localparam logic [4:0]  OPC_OFS_REL  = 5'h13;
    localparam logic [10:0] MODE_ZERO    = 11'h000;
    localparam logic [15:0] COORD_RESET  = 16'h0000;

    typedef logic signed [WORD_W-1:0] coord_t;
    typedef logic [OPC_W-1:0]         opcode_t;
endpackage

// *** verilog/coord_cmd_if.sv ***
// Interface carrying command words from list builder to coordinate engine
`timescale 1ns/100ps
interface coord_cmd_if;
    logic        valid;
    logic        ready;
    logic [15:0] word;

    modport host (output valid, output word, input ready);
    modport engine (input valid, input word, output ready);
endinterface

// *** verilog/coord_cmd_engine.sv ***
// Coordinate command interpreter: current pointer and local offset state
`timescale 1ns/100ps
module coord_cmd_engine
    import coord_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // Command link
    coord_cmd_if.engine                cmd,
    // Drawing side: absolute drawing scratch and relative drawing end vertex
    input  wire logic                  abs_draw_wr,
    input  wire coord_cmd_pkg::coord_t abs_draw_x,
    input  wire coord_cmd_pkg::coord_t abs_draw_y,
    input  wire logic                  rel_draw_done,
    input  wire coord_cmd_pkg::coord_t rel_end_x,
    input  wire coord_cmd_pkg::coord_t rel_end_y,
    // Raw coordinate from a drawing command, returned with offset applied
    input  wire coord_cmd_pkg::coord_t raw_x,
    input  wire coord_cmd_pkg::coord_t raw_y,
    output coord_cmd_pkg::coord_t      abs_x,
    output coord_cmd_pkg::coord_t      abs_y,
    // State for later drawing commands
    output coord_cmd_pkg::coord_t      pointer_x,
    output coord_cmd_pkg::coord_t      pointer_y,
    output coord_cmd_pkg::coord_t      offset_x,
    output coord_cmd_pkg::coord_t      offset_y,
    output logic                       cmd_done,
    output logic                       cmd_bad
);
    // ========================================
    // Command sequencer
    typedef enum logic [2:0] {
        ST_OP = 3'b001,
        ST_X  = 3'b010,
        ST_Y  = 3'b100
    } state_e;

    state_e  state_reg, state_next;
    opcode_t op_reg, op_next;
    coord_t  xp_reg, xp_next;
    logic    done_reg, done_next, bad_reg, bad_next;
    coord_t  px_reg, px_next, py_reg, py_next;
    coord_t  ox_reg, ox_next, oy_reg, oy_next;
    coord_t  bx_reg, bx_next, by_reg, by_next;
    coord_t  ax_reg, ax_next, ay_reg, ay_next;
    opcode_t word_op;
    coord_t  word_val;
    logic    frame_end;

    assign word_op   = cmd.word[OPC_LSB +: OPC_W];
    assign word_val  = coord_t'(cmd.word);
    // Always ready: every word is consumed in one cycle
    assign cmd.ready = 1'b1;
    // Y word of a frame: the command takes effect on this edge
    assign frame_end = (state_reg == ST_Y) && cmd.valid;

    always_comb begin
        state_next = state_reg;
        op_next    = op_reg;
        xp_next    = xp_reg;
        done_next  = 1'b0;
        bad_next   = 1'b0;
        unique case (state_reg)
            ST_OP: begin
                if (cmd.valid) begin
                    op_next = word_op;
                    if (word_op inside {OPC_MOVE_ABS, OPC_MOVE_REL, OPC_OFS_ABS,
                                        OPC_OFS_REL}) begin
                        state_next = ST_X;
                    end else begin
                        // Unknown word is dropped; the next one is read as an opcode
                        bad_next = 1'b1;
                    end
                end
            end
            ST_X: begin
                if (cmd.valid) begin
                    xp_next    = word_val;
                    state_next = ST_Y;
                end
            end
            ST_Y: begin
                if (cmd.valid) begin
                    state_next = ST_OP;
                    done_next  = 1'b1;
                end
            end
            default: begin
                state_next = ST_OP;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= ST_OP;
            op_reg    <= OPC_MOVE_ABS;
            xp_reg    <= COORD_RESET;
            done_reg  <= 1'b0;
            bad_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_reg    <= op_next;
            xp_reg    <= xp_next;
            done_reg  <= done_next;
            bad_reg   <= bad_next;
        end
    end

    // ========================================
    // Current pointer
    always_comb begin
        px_next = px_reg;
        py_next = py_reg;
        // Scratch writes by absolute drawing; pointer is not valid after
        if (abs_draw_wr) begin
            px_next = abs_draw_x;
            py_next = abs_draw_y;
        end
        // Relative drawing leaves its last vertex as the pointer
        if (rel_draw_done) begin
            px_next = rel_end_x;
            py_next = rel_end_y;
        end
        // Stored position carries the offset; offset commands leave it alone
        if (frame_end && (op_reg == OPC_MOVE_ABS)) begin
            px_next = coord_t'(xp_reg + ox_reg);
            py_next = coord_t'(word_val + oy_reg);
        end
        // Displacements move the stored position; no offset on top of them
        if (frame_end && (op_reg == OPC_MOVE_REL)) begin
            px_next = coord_t'(px_reg + xp_reg);
            py_next = coord_t'(py_reg + word_val);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            px_reg <= COORD_RESET;
            py_reg <= COORD_RESET;
        end else begin
            px_reg <= px_next;
            py_reg <= py_next;
        end
    end

    // ========================================
    // Local offset and the base that relative offsets build on
    always_comb begin
        ox_next = ox_reg;
        oy_next = oy_reg;
        bx_next = bx_reg;
        by_next = by_reg;
        if (frame_end && (op_reg == OPC_OFS_ABS)) begin
            ox_next = xp_reg;
            oy_next = word_val;
            bx_next = xp_reg;
            by_next = word_val;
        end
        // Relatives do not accumulate: each starts from the last absolute one
        if (frame_end && (op_reg == OPC_OFS_REL)) begin
            ox_next = coord_t'(bx_reg + xp_reg);
            oy_next = coord_t'(by_reg + word_val);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            // Offset is undefined to software; zero only for determinism
            ox_reg <= COORD_RESET;
            oy_reg <= COORD_RESET;
            bx_reg <= COORD_RESET;
            by_reg <= COORD_RESET;
        end else begin
            ox_reg <= ox_next;
            oy_reg <= oy_next;
            bx_reg <= bx_next;
            by_reg <= by_next;
        end
    end

    // ========================================
    // Coordinate adjust for drawing commands
    always_comb begin
        // Offset is added to every coordinate handed in
        ax_next = coord_t'(raw_x + ox_reg);
        ay_next = coord_t'(raw_y + oy_reg);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ax_reg <= COORD_RESET;
            ay_reg <= COORD_RESET;
        end else begin
            ax_reg <= ax_next;
            ay_reg <= ay_next;
        end
    end

    // ========================================
    // Outputs

    assign pointer_x = px_reg;
    assign pointer_y = py_reg;
    assign offset_x  = ox_reg;
    assign offset_y  = oy_reg;
    assign abs_x     = ax_reg;
    assign abs_y     = ay_reg;
    assign cmd_done  = done_reg;
    assign cmd_bad   = bad_reg;
endmodule

// *** verilog/coord_cmd_host.sv ***
// List builder end: turns user requests into three-word coordinate commands
`timescale 1ns/100ps
module coord_cmd_host
    import coord_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    // User request
    input  wire logic                   req_valid,
    input  wire coord_cmd_pkg::opcode_t req_op,
    input  wire coord_cmd_pkg::coord_t  req_x,
    input  wire coord_cmd_pkg::coord_t  req_y,
    output logic                        req_ready,
    // Command link
    coord_cmd_if.host                   cmd
);
    // ========================================
    // Word sender
    typedef enum logic [3:0] {
        SH_IDLE = 4'b0001,
        SH_OP   = 4'b0010,
        SH_X    = 4'b0100,
        SH_Y    = 4'b1000
    } hstate_e;

    hstate_e     st_reg, st_next;
    logic [15:0] w_reg, w_next;
    coord_t      hx_reg, hx_next, hy_reg, hy_next;
    logic        v_reg, v_next, rdy_reg, rdy_next;

    always_comb begin
        st_next  = st_reg;
        w_next   = w_reg;
        hx_next  = hx_reg;
        hy_next  = hy_reg;
        v_next   = v_reg;
        rdy_next = rdy_reg;
        unique case (st_reg)
            SH_IDLE: begin
                if (req_valid && rdy_reg) begin
                    // Mode bits all zero; command order is the requester's duty
                    w_next   = {req_op, MODE_ZERO};
                    hx_next  = req_x;
                    hy_next  = req_y;
                    v_next   = 1'b1;
                    rdy_next = 1'b0;
                    st_next  = SH_OP;
                end
            end
            SH_OP: begin
                if (cmd.ready) begin
                    w_next  = hx_reg;
                    st_next = SH_X;
                end
            end
            SH_X: begin
                if (cmd.ready) begin
                    w_next  = hy_reg;
                    st_next = SH_Y;
                end
            end
            SH_Y: begin
                if (cmd.ready) begin
                    v_next   = 1'b0;
                    rdy_next = 1'b1;
                    st_next  = SH_IDLE;
                end
            end
            default: begin
                st_next = SH_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_reg  <= SH_IDLE;
            w_reg   <= 16'h0000;
            hx_reg  <= COORD_RESET;
            hy_reg  <= COORD_RESET;
            v_reg   <= 1'b0;
            rdy_reg <= 1'b1;
        end else begin
            st_reg  <= st_next;
            w_reg   <= w_next;
            hx_reg  <= hx_next;
            hy_reg  <= hy_next;
            v_reg   <= v_next;
            rdy_reg <= rdy_next;
        end
    end

    assign cmd.valid = v_reg;
    assign cmd.word  = w_reg;
    assign req_ready = rdy_reg;
endmodule

// *** test/coord_cmd_asserts.sv ***
// Checker for the command link between list builder and engine
`timescale 1ns/100ps
module coord_cmd_asserts (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // Command link
    input wire logic        valid,
    input wire logic        ready,
    input wire logic [15:0] word
);
    logic [1:0] run_reg;
    logic [1:0] run_next;
    // ========================================
    // Run length of valid words, saturating so a stuck valid still trips
    always_comb begin
        run_next = 2'h0;
        if (valid) begin
            run_next = (run_reg == 2'h3) ? run_reg : run_reg + 2'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        run_reg <= rst ? 2'h0 : run_next;
    end
    // ========================================
    // Properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence frame_s;
        valid [*3] ##1 !valid;
    endsequence
    sequence opcode_s;
        word[15:11] inside {5'h10, 5'h11, 5'h12, 5'h13};
    endsequence
    chk_link_ready: assert property (ready)
        else $error("link not ready");
    chk_frame_words: assert property ($rose(valid) |-> frame_s)
        else $error("frame not three words");
    chk_opcode_known: assert property ($rose(valid) |-> opcode_s)
        else $error("unknown opcode sent");
    chk_mode_zero: assert property ($rose(valid) |-> word[10:0] == 11'h000)
        else $error("mode bits not zero");
    chk_run_bound: assert property (valid |-> run_reg != 2'h3)
        else $error("frame too long");
    chk_run_length: assert property ($fell(valid) && !$past(rst) |-> run_reg == 2'h3)
        else $error("frame too short");
    chk_frame_start: assert property ($rose(valid) |-> run_reg == 2'h0)
        else $error("frame starts mid run");
    chk_reset_idle: assert property (disable iff (1'b0) rst |=> !valid)
        else $error("valid during reset");
endmodule

// *** test/display_list_coordinate_commands_tb.sv ***
// Bench for the coordinate command host and engine joined by their link
`timescale 1ns/100ps
module display_list_coordinate_commands_tb;
    import coord_cmd_pkg::*;
    typedef struct {opcode_t op; coord_t x, y, px, py, ox, oy;} row_s;
    logic    core_clk = 1'b0, rst = 1'b1, req_valid = 1'b0;
    logic    abs_draw_wr = 1'b0, rel_draw_done = 1'b0;
    logic    req_ready, cmd_done, cmd_bad;
    opcode_t req_op = OPC_MOVE_ABS;
    coord_t  req_x = '0, req_y = '0, abs_draw_x = '0, abs_draw_y = '0;
    coord_t  rel_end_x = '0, rel_end_y = '0, raw_x = '0, raw_y = '0;
    coord_t  abs_x, abs_y, pointer_x, pointer_y, offset_x, offset_y;
    int      mismatches = 0, total_checks = 0;
    // Rows chain from an offset set first; each expects the state it leaves behind
    row_s    rows [7] = '{
        '{OPC_OFS_ABS,  16'h0010, 16'hfff0, 16'h0000, 16'h0000, 16'h0010, 16'hfff0},
        '{OPC_MOVE_ABS, 16'h1224, 16'h8010, 16'h1234, 16'h8000, 16'h0010, 16'hfff0},
        '{OPC_MOVE_REL, 16'hfffe, 16'h0001, 16'h1232, 16'h8001, 16'h0010, 16'hfff0},
        '{OPC_MOVE_REL, 16'h7fff, 16'hffff, 16'h9231, 16'h8000, 16'h0010, 16'hfff0},
        '{OPC_OFS_REL,  16'hfff8, 16'h0020, 16'h9231, 16'h8000, 16'h0008, 16'h0010},
        '{OPC_OFS_REL,  16'h0001, 16'h0001, 16'h9231, 16'h8000, 16'h0011, 16'hfff1},
        '{OPC_OFS_ABS,  16'h0003, 16'h0000, 16'h9231, 16'h8000, 16'h0003, 16'h0000}};

    coord_cmd_if link ();
    coord_cmd_host u_coord_cmd_host (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
        .req_op(req_op), .req_x(req_x), .req_y(req_y), .req_ready(req_ready), .cmd(link));
    coord_cmd_engine u_coord_cmd_engine (.core_clk(core_clk), .rst(rst), .cmd(link),
        .abs_draw_wr(abs_draw_wr), .abs_draw_x(abs_draw_x), .abs_draw_y(abs_draw_y),
        .rel_draw_done(rel_draw_done), .rel_end_x(rel_end_x), .rel_end_y(rel_end_y),
        .raw_x(raw_x), .raw_y(raw_y), .abs_x(abs_x), .abs_y(abs_y),
        .pointer_x(pointer_x), .pointer_y(pointer_y), .offset_x(offset_x),
        .offset_y(offset_y), .cmd_done(cmd_done), .cmd_bad(cmd_bad));
    coord_cmd_asserts u_coord_cmd_asserts (.core_clk(core_clk), .rst(rst),
        .valid(link.valid), .ready(link.ready), .word(link.word));

    initial forever #2.5 core_clk = ~core_clk;
    // ========================================
    // Tasks
    task automatic final_report();
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input coord_t exp, input coord_t got);
        total_checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            mismatches++;
        end
    endtask
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    task automatic pointer_is(input coord_t x, input coord_t y);
        check("pointer_x", x, pointer_x);
        check("pointer_y", y, pointer_y);
    endtask
    task automatic send(input row_s r);
        int n;
        n = 0;
        req_op = r.op;
        req_x = r.x;
        req_y = r.y;
        req_valid = 1'b1;
        tick();
        req_valid = 1'b0;
        while (cmd_done !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        if (cmd_done !== 1'b1) begin
            mismatches++;
            final_report();
        end
    endtask
    // ========================================
    // Main sequence
    initial begin
        repeat (20) tick();
        rst = 1'b0;
        pointer_is(16'h0000, 16'h0000);
        foreach (rows[i]) begin
            send(rows[i]);
            pointer_is(rows[i].px, rows[i].py);
            check("offset_x", rows[i].ox, offset_x);
            check("offset_y", rows[i].oy, offset_y);
            check("cmd_bad", 16'h0000, coord_t'(cmd_bad));
            $display("row %0d done", i);
        end
        raw_x = 16'h0100;
        raw_y = 16'hffff;
        tick();
        check("abs_x", 16'h0103, abs_x);
        check("abs_y", 16'hffff, abs_y);
        abs_draw_wr = 1'b1;
        abs_draw_x = 16'h0555;
        abs_draw_y = 16'h0aaa;
        tick();
        abs_draw_wr = 1'b0;
        pointer_is(16'h0555, 16'h0aaa);
        // Pointer is scratch after absolute drawing: set it again first
        send('{OPC_MOVE_ABS, 16'h00fd, 16'h0200, 0, 0, 0, 0});
        pointer_is(16'h0100, 16'h0200);
        abs_draw_wr = 1'b1;
        rel_draw_done = 1'b1;
        rel_end_x = 16'h0777;
        rel_end_y = 16'hf001;
        tick();
        abs_draw_wr = 1'b0;
        rel_draw_done = 1'b0;
        pointer_is(16'h0777, 16'hf001);
        send('{OPC_MOVE_REL, 16'h0001, 16'h0001, 0, 0, 0, 0});
        pointer_is(16'h0778, 16'hf002);
        $display("drawing side test done");
        req_valid = 1'b1;
        tick();
        req_valid = 1'b0;
        tick();
        rst = 1'b1;
        tick();
        rst = 1'b0;
        pointer_is(16'h0000, 16'h0000);
        check("offset_x", 16'h0000, offset_x);
        check("offset_y", 16'h0000, offset_y);
        check("req_ready", 16'h0001, coord_t'(req_ready));
        check("valid", 16'h0000, coord_t'(link.valid));
        check("cmd_done", 16'h0000, coord_t'(cmd_done));
        $display("reset test done");
        final_report();
    end
endmodule
